//--- src/strap_defs.svh
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH
// strap bit positions within the latched word
`define STRAP_BIT_LDO     0
`define STRAP_BIT_BOOT    1
`define STRAP_BIT_QUAL    2
`define STRAP_BIT_LOG     3
`define STRAP_BIT_SDIO    4
`define STRAP_COUNT       5
// default pull levels: qual pull-down, log/sdio/boot pull-up, ldo tied high in module
`define STRAP_PULL_DEFAULT 5'h1b
`define STRAP_RESET_VALUE  5'h1b
`endif

//--- src/strap_pkg.sv
package strap_pkg;
    typedef logic [4:0] strap_word_t;
    typedef enum logic {
        FLASH_VDD_3V3,
        FLASH_VDD_1V8
    } flash_vdd_e;
    typedef enum logic {
        BOOT_DOWNLOAD,
        BOOT_SPI_FLASH
    } boot_src_e;
    typedef enum logic {
        EDGE_FALLING,
        EDGE_RISING
    } sdio_edge_e;
endpackage

//--- src/strap_if.sv
`timescale 1ns/100ps
interface strap_if;
    import strap_pkg::*;
    strap_word_t pins;
    strap_word_t latched;
    logic        capture;
    modport latch (input pins, input capture, output latched);
    modport user  (output pins, output capture, input latched);
endinterface

//--- src/strap_capture.sv
`timescale 1ns/100ps
`include "strap_defs.svh"
module strap_capture (
    input wire logic clk,
    input wire logic rst_n,
    strap_if.latch   sif
);
    import strap_pkg::*;

    strap_word_t latched_q;
    logic        done_q;

    // capture once on the release edge; later pin activity is ignored until the next reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latched_q <= `STRAP_RESET_VALUE;
        end else if (sif.capture && !done_q) begin
            latched_q <= sif.pins;
        end
    end

    assign sif.latched = latched_q;
endmodule

//--- src/boot_strap_latch_decode.sv
// Summary of operation
// - every system reset samples the four strap pins and the tied-high ldo bit into latches.
// - latched straps stay unchanged until the next reset or enable drop, whatever the pins do.
// - the five latched bits are readable as a status word.
// - during reset each strap pin has its own weak pull applied.
// - after reset the strap pins return to normal functional use.
// - ldo strap 0 selects 3.3 V flash supply, 1 selects 1.8 V.
// - boot select 1 gives flash boot; both pins 0 give download boot.
// - log strap 1 enables boot log on console uart tx, 0 silences.
// - log strap picks sdio input edge, sdio strap picks output edge.
// - firmware override bits replace strap-derived supply and sdio timing.
// - ldo strap is tied high inside the module, giving 1.8 V.
`timescale 1ns/100ps
`include "strap_defs.svh"
module boot_strap_latch_decode (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 module_enable,
    input  wire logic                 boot_select_pin,
    input  wire logic                 boot_qualifier_pin,
    input  wire logic                 log_and_timing_strap_pin,
    input  wire logic                 sdio_timing_strap_pin,
    input  wire logic                 vdd_override_en,
    input  wire strap_pkg::flash_vdd_e vdd_override_val,
    input  wire logic                 sdio_override_en,
    input  wire strap_pkg::sdio_edge_e sdio_in_override_val,
    input  wire strap_pkg::sdio_edge_e sdio_out_override_val,
    output      strap_pkg::strap_word_t strap_status,
    output      logic                 strap_pull_en,
    output      strap_pkg::strap_word_t strap_pull_level,
    output      logic                 strap_pins_functional,
    output      strap_pkg::flash_vdd_e flash_vdd_sel,
    output      strap_pkg::boot_src_e boot_source,
    output      logic                 download_boot_valid,
    output      logic                 boot_log_enable,
    output      strap_pkg::sdio_edge_e sdio_in_edge,
    output      strap_pkg::sdio_edge_e sdio_out_edge
);
    import strap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // capture
    // the capture module keeps the latched word; the pins are sampled once
    // per reset and later pin activity cannot reach it
    strap_if     sif ();
    strap_word_t raw_pins;
    strap_word_t word;
    logic        run;

    // ldo strap has no module pin: it is tied high internally
    always_comb begin
        raw_pins[`STRAP_BIT_LDO]  = 1'b1;
        raw_pins[`STRAP_BIT_BOOT] = boot_select_pin;
        raw_pins[`STRAP_BIT_QUAL] = boot_qualifier_pin;
        raw_pins[`STRAP_BIT_LOG]  = log_and_timing_strap_pin;
        raw_pins[`STRAP_BIT_SDIO] = sdio_timing_strap_pin;
    end
    assign sif.pins    = raw_pins;
    assign sif.capture = module_enable;
    assign run         = rst_n && module_enable;

    // module_enable low is treated as reset, so the straps are sampled again
    // on every enable release as well as on every rst_n release
    strap_capture u_capture (
        .clk   (clk),
        .rst_n (run),
        .sif   (sif)
    );

    // decode from the live pins in the capture cycle so outputs are valid
    // on the release edge itself rather than one cycle late
    // first_q marks the capture cycle: high through reset and on the first running edge
    logic first_q;
    always_ff @(posedge clk) begin
        if (!run) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end
    // after the capture edge only the latch is used, so pin activity is ignored
    assign word = first_q ? raw_pins : sif.latched;

    ////////////////////////////////////////////////////////////////////////////
    // pulls and pin ownership
    // a floating pin must read its default level, so the pulls stand
    // for the whole reset and drop on the first running edge
    always_ff @(posedge clk) begin
        if (!run) begin
            strap_pull_en <= 1'b1;
        end else begin
            strap_pull_en <= 1'b0;
        end
    end

    // pull direction per bit: qualifier down, the others up, ldo tied high
    // kept in a flop so that every output stays registered
    always_ff @(posedge clk) begin
        if (!run) begin
            strap_pull_level <= `STRAP_PULL_DEFAULT;
        end else begin
            strap_pull_level <= `STRAP_PULL_DEFAULT;
        end
    end

    // the pad mux hands the pins back to their normal functions once running
    always_ff @(posedge clk) begin
        if (!run) begin
            strap_pins_functional <= 1'b0;
        end else begin
            strap_pins_functional <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap-derived settings, before any firmware override
    // computed from word so the capture edge and later edges share one path
    // the sdio input edge shares its strap with the boot log enable
    flash_vdd_e strap_vdd;
    boot_src_e  strap_boot;
    logic       strap_dl_ok;
    logic       strap_log;
    sdio_edge_e strap_sdio_in;
    sdio_edge_e strap_sdio_out;

    always_comb begin
        strap_vdd      = flash_vdd_e'(word[`STRAP_BIT_LDO]);
        strap_boot     = word[`STRAP_BIT_BOOT] ? BOOT_SPI_FLASH : BOOT_DOWNLOAD;
        // boot select 0 with qualifier 1 is not a defined mode
        strap_dl_ok    = !word[`STRAP_BIT_BOOT] && !word[`STRAP_BIT_QUAL];
        strap_log      = word[`STRAP_BIT_LOG];
        strap_sdio_in  = sdio_edge_e'(word[`STRAP_BIT_LOG]);
        strap_sdio_out = sdio_edge_e'(word[`STRAP_BIT_SDIO]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // firmware overrides
    // overrides are ignored on the capture edge itself, so every reset shows
    // the strap decode for at least one cycle before firmware can replace it
    logic ovr_live;
    logic vdd_ovr_take;
    logic sdio_ovr_take;

    assign ovr_live      = !first_q;
    assign vdd_ovr_take  = vdd_override_en && ovr_live;
    assign sdio_ovr_take = sdio_override_en && ovr_live;

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs, one process per setting
    // reset values match the pull defaults so a held reset reads as idle
    // status mirrors the latch so firmware reads back exactly what was sampled
    always_ff @(posedge clk) begin
        if (!run) begin
            strap_status <= `STRAP_RESET_VALUE;
        end else begin
            strap_status <= word;
        end
    end

    // the strap always yields 1.8 V here; only firmware can pick 3.3 V
    always_ff @(posedge clk) begin
        if (!run) begin
            flash_vdd_sel <= FLASH_VDD_1V8;
        end else if (vdd_ovr_take) begin
            flash_vdd_sel <= vdd_override_val;
        end else begin
            flash_vdd_sel <= strap_vdd;
        end
    end

    // boot source is fixed for the whole run; no override exists for it
    always_ff @(posedge clk) begin
        if (!run) begin
            boot_source <= BOOT_SPI_FLASH;
        end else begin
            boot_source <= strap_boot;
        end
    end

    // lets the boot code refuse to run from an undefined strap combination
    always_ff @(posedge clk) begin
        if (!run) begin
            download_boot_valid <= 1'b0;
        end else begin
            download_boot_valid <= strap_dl_ok;
        end
    end

    // gates the boot log on the console uart tx line
    always_ff @(posedge clk) begin
        if (!run) begin
            boot_log_enable <= 1'b1;
        end else begin
            boot_log_enable <= strap_log;
        end
    end

    // both edges use the same take signal so the slave never sees a mix
    // of override and strap timing
    always_ff @(posedge clk) begin
        if (!run) begin
            sdio_in_edge <= EDGE_RISING;
        end else if (sdio_ovr_take) begin
            sdio_in_edge <= sdio_in_override_val;
        end else begin
            sdio_in_edge <= strap_sdio_in;
        end
    end

    // out edge follows the sdio strap, in edge the log strap
    always_ff @(posedge clk) begin
        if (!run) begin
            sdio_out_edge <= EDGE_RISING;
        end else if (sdio_ovr_take) begin
            sdio_out_edge <= sdio_out_override_val;
        end else begin
            sdio_out_edge <= strap_sdio_out;
        end
    end
endmodule

//--- dv/strap_host.sv
`timescale 1ns/100ps
module strap_host (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       module_enable,
    input  wire logic [3:0] sel,
    output      logic       boot_select_pin,
    output      logic       boot_qualifier_pin,
    output      logic       log_and_timing_strap_pin,
    output      logic       sdio_timing_strap_pin
);
    logic [3:0] cnt_q;
    logic       live_q;
    always_ff @(posedge clk) live_q <= rst_n & module_enable;
    always_ff @(posedge clk) cnt_q <= live_q ? cnt_q + 4'h1 : 4'h0;
    // after capture the pins step through an inverted count every cycle, as busy normal io would
    assign {sdio_timing_strap_pin, log_and_timing_strap_pin, boot_qualifier_pin,
            boot_select_pin} = live_q ? ~sel ^ cnt_q : sel;
endmodule

//--- dv/strap_chk_sva.sv
`timescale 1ns/100ps
module strap_chk import strap_pkg::*; (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        module_enable,
    input wire logic        boot_select_pin,
    input wire logic        boot_qualifier_pin,
    input wire logic        log_and_timing_strap_pin,
    input wire logic        sdio_timing_strap_pin,
    input wire logic        vdd_override_en,
    input wire flash_vdd_e  vdd_override_val,
    input wire logic        sdio_override_en,
    input wire sdio_edge_e  sdio_in_override_val,
    input wire sdio_edge_e  sdio_out_override_val,
    input wire strap_word_t strap_status,
    input wire logic        strap_pull_en,
    input wire strap_word_t strap_pull_level,
    input wire logic        strap_pins_functional,
    input wire flash_vdd_e  flash_vdd_sel,
    input wire boot_src_e   boot_source,
    input wire logic        download_boot_valid,
    input wire logic        boot_log_enable,
    input wire sdio_edge_e  sdio_in_edge,
    input wire sdio_edge_e  sdio_out_edge
);
    wire  run = rst_n & module_enable;
    logic r_q;
    always_ff @(posedge clk) r_q <= run;
    default clocking @(posedge clk); endclocking
    default disable iff (!run);
    AST_RESET: assert property (disable iff (1'b0) !run |=> strap_pull_en
        && !strap_pins_functional && strap_status == 5'h1b && strap_pull_level == 5'h1b)
        else $error("reset");
    AST_CAPTURE: assert property (run && !r_q |=> strap_status ==
        {$past(sdio_timing_strap_pin), $past(log_and_timing_strap_pin),
        $past(boot_qualifier_pin), $past(boot_select_pin), 1'b1}) else $error("capture");
    AST_HOLD: assert property (r_q |=> $stable(strap_status)) else $error("hold");
    AST_FUNC: assert property (run |=> !strap_pull_en && strap_pins_functional)
        else $error("function");
    AST_VDD: assert property (!(vdd_override_en && r_q) |=>
        flash_vdd_sel == FLASH_VDD_1V8) else $error("vdd");
    AST_OVR: assert property (r_q |=>
        (!$past(vdd_override_en) || flash_vdd_sel == $past(vdd_override_val)) &&
        (!$past(sdio_override_en) || sdio_in_edge == $past(sdio_in_override_val) &&
        sdio_out_edge == $past(sdio_out_override_val))) else $error("override");
    AST_BOOT: assert property (run |=> boot_source == boot_src_e'(strap_status[1]) &&
        (strap_status[1] || download_boot_valid == !strap_status[2])) else $error("boot");
    AST_EDGE: assert property (!(sdio_override_en && r_q) |=>
        boot_log_enable == strap_status[3] && sdio_in_edge == sdio_edge_e'(strap_status[3])
        && sdio_out_edge == sdio_edge_e'(strap_status[4])) else $error("edge");
endmodule
bind boot_strap_latch_decode strap_chk chk (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .module_enable            (module_enable),
    .boot_select_pin          (boot_select_pin),
    .boot_qualifier_pin       (boot_qualifier_pin),
    .log_and_timing_strap_pin (log_and_timing_strap_pin),
    .sdio_timing_strap_pin    (sdio_timing_strap_pin),
    .vdd_override_en          (vdd_override_en),
    .vdd_override_val         (vdd_override_val),
    .sdio_override_en         (sdio_override_en),
    .sdio_in_override_val     (sdio_in_override_val),
    .sdio_out_override_val    (sdio_out_override_val),
    .strap_status             (strap_status),
    .strap_pull_en            (strap_pull_en),
    .strap_pull_level         (strap_pull_level),
    .strap_pins_functional    (strap_pins_functional),
    .flash_vdd_sel            (flash_vdd_sel),
    .boot_source              (boot_source),
    .download_boot_valid      (download_boot_valid),
    .boot_log_enable          (boot_log_enable),
    .sdio_in_edge             (sdio_in_edge),
    .sdio_out_edge            (sdio_out_edge)
);

//--- dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import strap_pkg::*;
    logic clk, rst_n, module_enable, vdd_override_en, sdio_override_en, strap_pull_en;
    logic strap_pins_functional, download_boot_valid, boot_log_enable, boot_select_pin;
    logic boot_qualifier_pin, log_and_timing_strap_pin, sdio_timing_strap_pin;
    logic [3:0] sel;
    logic [15:0] lfsr;
    logic [2:0] exp_cfg;
    strap_word_t strap_status, strap_pull_level;
    flash_vdd_e vdd_override_val, flash_vdd_sel;
    boot_src_e boot_source;
    sdio_edge_e sdio_in_override_val, sdio_out_override_val, sdio_in_edge, sdio_out_edge;
    int num_errors = 0, n_checks = 0, cycles = 0;
    boot_strap_latch_decode dut (
        .clk                      (clk),
        .rst_n                    (rst_n),
        .module_enable            (module_enable),
        .boot_select_pin          (boot_select_pin),
        .boot_qualifier_pin       (boot_qualifier_pin),
        .log_and_timing_strap_pin (log_and_timing_strap_pin),
        .sdio_timing_strap_pin    (sdio_timing_strap_pin),
        .vdd_override_en          (vdd_override_en),
        .vdd_override_val         (vdd_override_val),
        .sdio_override_en         (sdio_override_en),
        .sdio_in_override_val     (sdio_in_override_val),
        .sdio_out_override_val    (sdio_out_override_val),
        .strap_status             (strap_status),
        .strap_pull_en            (strap_pull_en),
        .strap_pull_level         (strap_pull_level),
        .strap_pins_functional    (strap_pins_functional),
        .flash_vdd_sel            (flash_vdd_sel),
        .boot_source              (boot_source),
        .download_boot_valid      (download_boot_valid),
        .boot_log_enable          (boot_log_enable),
        .sdio_in_edge             (sdio_in_edge),
        .sdio_out_edge            (sdio_out_edge)
    );
    strap_host host (
        .clk                      (clk),
        .rst_n                    (rst_n),
        .module_enable            (module_enable),
        .sel                      (sel),
        .boot_select_pin          (boot_select_pin),
        .boot_qualifier_pin       (boot_qualifier_pin),
        .log_and_timing_strap_pin (log_and_timing_strap_pin),
        .sdio_timing_strap_pin    (sdio_timing_strap_pin)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [15:0] step(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // supply and sdio edges once overrides are live; ldo strap is always 1
    function automatic logic [2:0] cfg();
        return {vdd_override_en ? vdd_override_val : FLASH_VDD_1V8,
                sdio_override_en ? sdio_in_override_val : sdio_edge_e'(sel[2]),
                sdio_override_en ? sdio_out_override_val : sdio_edge_e'(sel[3])};
    endfunction
    initial begin
        {rst_n, module_enable, vdd_override_en, sdio_override_en, sel} = 8'h40;
        vdd_override_val      = FLASH_VDD_3V3;
        sdio_in_override_val  = EDGE_FALLING;
        sdio_out_override_val = EDGE_FALLING;
        lfsr = 16'h7223;
        repeat (5) @(posedge clk);
        #1;
        // first 16 passes walk every strap combination, the rest are random
        for (int i = 0; i < 40; i++) begin
            lfsr = step(lfsr);
            sel = i < 16 ? 4'(i) : lfsr[3:0];
            if (i[0]) module_enable = 1'b0;
            else rst_n = 1'b0;
            @(posedge clk) #1;
            chk("reset pins", 8'({strap_pull_en, strap_pins_functional}), 8'h2);
            chk("pull level", 8'(strap_pull_level), 8'h1b);
            chk("reset status", 8'(strap_status), 8'h1b);
            {rst_n, module_enable, vdd_override_en, sdio_override_en} = {2'b11, lfsr[5:4]};
            vdd_override_val      = flash_vdd_e'(lfsr[8]);
            sdio_in_override_val  = sdio_edge_e'(lfsr[7]);
            sdio_out_override_val = sdio_edge_e'(lfsr[6]);
            @(posedge clk) #1;
            chk("status", 8'(strap_status), 8'({sel, 1'b1}));
            chk("boot", 8'(boot_source), 8'(sel[0]));
            chk("log", 8'(boot_log_enable), 8'(sel[2]));
            chk("run pins", 8'({strap_pull_en, strap_pins_functional}), 8'h1);
            chk("dl valid", 8'(download_boot_valid), 8'(~|sel[1:0]));
            @(posedge clk) #1;
            exp_cfg = cfg();
            chk("held", 8'(strap_status), 8'({sel, 1'b1}));
            chk("vdd sel", 8'(flash_vdd_sel), 8'(exp_cfg[2]));
            chk("sdio", 8'({sdio_in_edge, sdio_out_edge}), 8'(exp_cfg[1:0]));
        end
        close_out();
    end
endmodule
